// [hw/srd_pkg.sv]
// Package: address map, field layouts and reset values of the special-function region decoder
package srd_pkg;

  // ----------------------------------------------------------------
  // Address space
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 8;
  localparam logic [11:0] SFR_BASE        = 12'h0F80;
  localparam logic [11:0] SFR_TOP         = 12'h0FFF;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
  localparam logic [3:0]  SFR_BANK        = 4'hF;
  localparam logic [3:0]  GPR_BANK        = 4'h0;
  localparam logic [3:0]  IMPL_BANK_MASK  = 4'h1;  // Banks 0 and 1 only are populated
  // Unassigned special-function offsets, one bit per address above the region base
  localparam logic [127:0] HOLE_MAP       = 128'h0000_0000_0010_1FE0_FECE_0400_1010_0000;
  // Indirect alias groups: five alias addresses each, counted downward
  localparam logic [11:0] ALIAS0_BASE     = 12'h0FEF;
  localparam logic [11:0] ALIAS1_BASE     = 12'h0FE7;
  localparam logic [11:0] ALIAS2_BASE     = 12'h0FDF;
  localparam logic [11:0] ALIAS_SPAN      = 12'h0004;

  // ----------------------------------------------------------------
  // Core register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_TBLPTR_LO   = 12'h0FF6;
  localparam logic [11:0] OFS_TBLPTR_HI   = 12'h0FF7;
  localparam logic [11:0] OFS_TBLPTR_UP   = 12'h0FF8;
  localparam logic [11:0] OFS_PC_LO       = 12'h0FF9;
  localparam logic [11:0] OFS_PCH_LATCH   = 12'h0FFA;
  localparam logic [11:0] OFS_PCU_LATCH   = 12'h0FFB;
  localparam logic [11:0] OFS_STK_PTR     = 12'h0FFC;
  localparam logic [11:0] OFS_TOS_LO      = 12'h0FFD;
  localparam logic [11:0] OFS_TOS_HI      = 12'h0FFE;
  localparam logic [11:0] OFS_TOS_UP      = 12'h0FFF;
  localparam logic [11:0] OFS_BANK_SEL    = 12'h0FE0;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  MASK_FULL       = 8'hFF;
  localparam logic [7:0]  MASK_UP5        = 8'h1F;  // Bits 4:0
  localparam logic [7:0]  MASK_UP6        = 8'h3F;  // Bits 5:0 (table pointer bit 21)
  localparam logic [7:0]  MASK_RETURN_STACK_POINTER     = 8'hDF;  // Full, underflow, pointer 4:0
  localparam logic [7:0]  MASK_BANK       = 8'h0F;
  localparam logic [7:0]  RST_ZERO        = 8'h00;

  // Indices of the core register file
  typedef enum logic [3:0] {
    SRD_TBL_LO, SRD_TBL_HI, SRD_TBL_UP, SRD_PC_LO, SRD_PCH, SRD_PCU,
    SRD_STK, SRD_TOS_LO, SRD_TOS_HI, SRD_TOS_UP, SRD_BSEL, SRD_NONE
  } srd_idx_e;

  localparam int NUM_REGS = 11;

endpackage : srd_pkg

// [hw/srd_dec_if.sv]
// Interface: decoded access from the address resolver to the register store
`timescale 1ns/100ps
interface srd_dec_if;
  import srd_pkg::*;
  logic [11:0] full_addr;  // Resolved 12-bit address
  logic        in_sfr;     // Address lies in the special-function region
  logic        is_alias;   // Address is an indirect alias (no storage)
  logic        in_gpr;     // Address lies in populated RAM bank
  srd_idx_e    reg_idx;    // Core register hit, or none

  modport resolver (output full_addr, in_sfr, is_alias, in_gpr, reg_idx);
  modport store    (input  full_addr, in_sfr, is_alias, in_gpr, reg_idx);
endinterface : srd_dec_if

// [hw/srd_resolve.sv]
// Module: turns an instruction operand and bank value into a decoded 12-bit address
`timescale 1ns/100ps
module srd_resolve
  import srd_pkg::*;
(
  input  wire logic       use_full,  // Operand carries a full 12-bit address
  input  wire logic       acc_bit,   // Instruction access bit
  input  wire logic [11:0] addr_in,  // Operand address
  input  wire logic [3:0] bank_val,  // Current bank selector value
  srd_dec_if.resolver     dec        // Decoded result
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address falls inside one five-entry alias group
  function automatic logic in_group(input logic [11:0] a, input logic [11:0] base);
    in_group = (a <= base) && (a >= base - ALIAS_SPAN);
  endfunction : in_group

  // ----------------------------------------------------------------
  // Address resolution and decode
  // ----------------------------------------------------------------
  logic [11:0] fa;

  // Build the full address from the addressing mode
  always_comb begin
    if (use_full) begin
      fa = addr_in;
    end else if (!acc_bit) begin
      fa = (addr_in[7:0] >= ACCESS_SPLIT) ? {SFR_BANK, addr_in[7:0]}
                                          : {GPR_BANK, addr_in[7:0]};
    end else begin
      fa = {bank_val, addr_in[7:0]};
    end
  end

  // Classify the resolved address
  always_comb begin
    dec.full_addr = fa;
    dec.in_sfr    = (fa >= SFR_BASE) && (fa <= SFR_TOP);
    dec.in_gpr    = ((fa[11:8] & ~IMPL_BANK_MASK) == 4'h0);
    dec.is_alias  = dec.in_sfr && (in_group(fa, ALIAS0_BASE) ||
                    in_group(fa, ALIAS1_BASE) || in_group(fa, ALIAS2_BASE));
    unique case (fa)
      OFS_TBLPTR_LO: dec.reg_idx = SRD_TBL_LO;
      OFS_TBLPTR_HI: dec.reg_idx = SRD_TBL_HI;
      OFS_TBLPTR_UP: dec.reg_idx = SRD_TBL_UP;
      OFS_PC_LO:     dec.reg_idx = SRD_PC_LO;
      OFS_PCH_LATCH: dec.reg_idx = SRD_PCH;
      OFS_PCU_LATCH: dec.reg_idx = SRD_PCU;
      OFS_STK_PTR:   dec.reg_idx = SRD_STK;
      OFS_TOS_LO:    dec.reg_idx = SRD_TOS_LO;
      OFS_TOS_HI:    dec.reg_idx = SRD_TOS_HI;
      OFS_TOS_UP:    dec.reg_idx = SRD_TOS_UP;
      OFS_BANK_SEL:  dec.reg_idx = SRD_BSEL;
      default:       dec.reg_idx = SRD_NONE;
    endcase
  end

endmodule : srd_resolve

// [hw/srd_top.sv]
// Module: special-function region decoder with the core register store
// Access contract
// A read or write is taken at the rising edge with its strobe high.
// Read data shows after that edge and holds until the next read.
// Back-to-back accesses are allowed; a read sees the write just before it.
// Holes, aliases and empty banks read zero and keep no write.
// Alias accesses only raise alias_hit; the pointer path lives in the core.
// Core registers are plain storage; stack and counter motion live in the core.
// Unimplemented bits of masked registers read zero.
`timescale 1ns/100ps
module srd_top
  import srd_pkg::*;
(
  input  wire logic        clock,       // 40 MHz core clock
  input  wire logic        rst_n,       // Synchronous reset, active low
  input  wire logic        rd_en,       // Read strobe from the core
  input  wire logic        wr_en,       // Write strobe from the core
  input  wire logic        use_full,    // Operand is a full 12-bit address
  input  wire logic        acc_bit,     // Instruction access bit
  input  wire logic [11:0] addr,        // Operand address
  input  wire logic [7:0]  wr_data,     // Write data
  input  wire logic [7:0]  periph_rdata,// Read data from peripheral registers
  input  wire logic [7:0]  gpr_rdata,   // Read data from general purpose RAM
  output logic      [7:0]  rd_data,     // Registered read data
  output logic      [11:0] mem_addr,    // Resolved address to RAM and peripherals
  output logic             gpr_sel,     // Access goes to general purpose RAM
  output logic             gpr_wr,      // Write strobe to general purpose RAM
  output logic             periph_sel,  // Access goes to a peripheral register
  output logic             periph_wr,   // Write strobe to peripheral registers
  output logic             alias_hit,   // Access targets an indirect alias
  output logic      [1:0]  alias_group, // Which pointer group the alias belongs to
  output logic      [3:0]  bank_sel,    // Current bank selector value
  output logic      [20:0] tos_value,   // Top-of-stack value
  output logic      [21:0] tbl_ptr,     // Table pointer value
  output logic      [7:0]  stk_ptr      // Stack pointer register value
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Implemented-bit mask of one core register
  function automatic logic [7:0] reg_mask(input srd_idx_e i);
    unique case (i)
      SRD_TBL_UP:               reg_mask = MASK_UP6;
      SRD_PCU, SRD_TOS_UP:      reg_mask = MASK_UP5;
      SRD_STK:                  reg_mask = MASK_RETURN_STACK_POINTER;
      SRD_BSEL:                 reg_mask = MASK_BANK;
      SRD_NONE:                 reg_mask = RST_ZERO;
      default:                  reg_mask = MASK_FULL;
    endcase
  endfunction : reg_mask

  // Unassigned offset inside the special-function region
  function automatic logic is_hole(input logic [11:0] a);
    is_hole = (a >= SFR_BASE) && HOLE_MAP[a[6:0]];
  endfunction : is_hole

  // Pointer group of an alias address, highest group first
  function automatic logic [1:0] alias_grp(input logic [11:0] a);
    if (a >= ALIAS0_BASE - ALIAS_SPAN) begin
      alias_grp = 2'h0;
    end else if (a >= ALIAS1_BASE - ALIAS_SPAN) begin
      alias_grp = 2'h1;
    end else begin
      alias_grp = 2'h2;
    end
  endfunction : alias_grp

  // Source of the next read data
  typedef enum logic [1:0] {
    SRD_SRC_CORE, SRD_SRC_PERIPH, SRD_SRC_GPR, SRD_SRC_ZERO
  } srd_src_e;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  srd_dec_if dec ();

  srd_resolve u_resolve (
    .use_full (use_full),
    .acc_bit  (acc_bit),
    .addr_in  (addr),
    .bank_val (bank_sel),
    .dec      (dec)
  );

  // ----------------------------------------------------------------
  // Access classification
  // ----------------------------------------------------------------
  logic core_hit;
  logic hole_hit;
  logic periph_hit;

  // Classify the access: core store, hole, alias or peripheral
  always_comb begin
    core_hit   = dec.in_sfr && (dec.reg_idx != SRD_NONE);
    hole_hit   = dec.in_sfr && is_hole(dec.full_addr);
    periph_hit = dec.in_sfr && !core_hit && !hole_hit && !dec.is_alias;
  end

  // Drive the selects; holes and aliases reach no store
  always_comb begin
    mem_addr    = dec.full_addr;
    alias_hit   = dec.is_alias;
    alias_group = alias_grp(dec.full_addr);
    periph_sel  = periph_hit;
    periph_wr   = periph_hit && wr_en;
    gpr_sel     = !dec.in_sfr && dec.in_gpr;
    gpr_wr      = gpr_sel && wr_en;
  end

  // ----------------------------------------------------------------
  // Core register store
  // ----------------------------------------------------------------
  logic [7:0] regs_ff [NUM_REGS];
  logic [7:0] nxt_regs [NUM_REGS];
  logic       reg_wr [NUM_REGS];

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // One write enable per core register; only a core hit may write
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      reg_wr[i] = wr_en && core_hit && (int'(dec.reg_idx) == i);
    end
  end

  // Masked write into the addressed core register
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      nxt_regs[i] = regs_ff[i];
      if (reg_wr[i]) begin
        nxt_regs[i] = wr_data & reg_mask(dec.reg_idx);
      end
    end
  end

  // Register the store; all clear on reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= RST_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // Exported core state
  always_comb begin
    bank_sel  = regs_ff[SRD_BSEL][3:0];
    tos_value = {regs_ff[SRD_TOS_UP][4:0], regs_ff[SRD_TOS_HI], regs_ff[SRD_TOS_LO]};
    tbl_ptr   = {regs_ff[SRD_TBL_UP][5:0], regs_ff[SRD_TBL_HI], regs_ff[SRD_TBL_LO]};
    stk_ptr   = regs_ff[SRD_STK];
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic [7:0] core_rd;
  srd_src_e   rd_src;

  // Masked view of the addressed core register; index guarded by the hit
  always_comb begin
    core_rd = RST_ZERO;
    if (core_hit) begin
      core_rd = regs_ff[dec.reg_idx] & reg_mask(dec.reg_idx);
    end
  end

  // Pick the read source; holes, aliases and empty banks give zero
  always_comb begin
    if (core_hit) begin
      rd_src = SRD_SRC_CORE;
    end else if (periph_hit) begin
      rd_src = SRD_SRC_PERIPH;
    end else if (gpr_sel) begin
      rd_src = SRD_SRC_GPR;
    end else begin
      rd_src = SRD_SRC_ZERO;
    end
  end

  // Next read data; it holds while no read is taken
  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (rd_en) begin
      unique case (rd_src)
        SRD_SRC_CORE:   nxt_rd_data = core_rd;
        SRD_SRC_PERIPH: nxt_rd_data = periph_rdata;
        SRD_SRC_GPR:    nxt_rd_data = gpr_rdata;
        SRD_SRC_ZERO:   nxt_rd_data = RST_ZERO;
      endcase
    end
  end

  // Register read data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_ff <= RST_ZERO;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

endmodule : srd_top

// [tb/srd_top_props.sv]
// Checker: decode and core register properties of the region decoder
`timescale 1ns/100ps
module srd_top_props
  import srd_pkg::*;
(
  input wire logic        clock,      // Core clock
  input wire logic        rst_n,      // Sync reset, active low
  input wire logic        rd_en,      // Read strobe
  input wire logic        wr_en,      // Write strobe
  input wire logic        use_full,   // Full address operand
  input wire logic        acc_bit,    // Access bit
  input wire logic [11:0] addr,       // Operand address
  input wire logic [7:0]  wr_data,    // Write data
  input wire logic [7:0]  rd_data,    // Read data
  input wire logic [11:0] mem_addr,   // Resolved address
  input wire logic        gpr_sel,    // RAM select
  input wire logic        gpr_wr,     // RAM write
  input wire logic        periph_sel, // Peripheral select
  input wire logic        alias_hit,  // Alias access
  input wire logic [3:0]  bank_sel,   // Bank selector
  input wire logic [20:0] tos_value   // Stack top
);
  logic [7:0] wr_data_ff;
  // ----------------------------------------------------------------
  // Helper: write data of the previous cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    wr_data_ff <= wr_data;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_reset_clear: assert property ($rose(rst_n) |-> tos_value == 21'h0 && bank_sel == 4'h0)
    else $error("state not cleared by reset");
  a_sfr_region: assert property (periph_sel |-> mem_addr >= SFR_BASE && !alias_hit)
    else $error("peripheral select outside region");
  a_alias_empty: assert property (rd_en && alias_hit |=> rd_data == 8'h00)
    else $error("alias read returned data");
  a_alias_nosel: assert property (alias_hit |-> !gpr_sel && !periph_sel)
    else $error("alias reached a store");
  a_unpop_zero: assert property (rd_en && !gpr_sel && !periph_sel &&
    mem_addr < SFR_BASE |=> rd_data == 8'h00)
    else $error("unpopulated bank read not zero");
  a_hole_zero: assert property (rd_en && mem_addr >= SFR_BASE &&
    HOLE_MAP[mem_addr[6:0]] |=> rd_data == 8'h00)
    else $error("hole read not zero");
  a_hole_quiet: assert property (mem_addr >= SFR_BASE &&
    HOLE_MAP[mem_addr[6:0]] |-> !periph_sel && !gpr_sel)
    else $error("hole reached a store");
  a_gpr_bank: assert property (gpr_wr |-> wr_en && mem_addr[11:9] == 3'h0)
    else $error("RAM write outside populated banks");
  a_access_map: assert property (!use_full && !acc_bit |->
    mem_addr == {addr[7] ? SFR_BANK : GPR_BANK, addr[7:0]})
    else $error("access bank mapping wrong");
  a_bank_map: assert property (!use_full && acc_bit |-> mem_addr == {bank_sel, addr[7:0]})
    else $error("banked mapping wrong");
  a_bank_low: assert property (wr_en && mem_addr == OFS_BANK_SEL |=> bank_sel == wr_data_ff[3:0])
    else $error("bank selector write wrong");
  a_tos_upper: assert property (wr_en && mem_addr == OFS_TOS_UP |=> tos_value[20:16] == wr_data_ff[4:0])
    else $error("stack top upper write wrong");
endmodule : srd_top_props
bind srd_top srd_top_props i_srd_top_props (.clock, .rst_n, .rd_en, .wr_en, .use_full, .acc_bit, .addr, .wr_data,
  .rd_data, .mem_addr, .gpr_sel, .gpr_wr, .periph_sel, .alias_hit, .bank_sel, .tos_value);

// [tb/srd_mem_model.sv]
// Model: RAM and peripheral stores behind the region decoder
`timescale 1ns/100ps
module srd_mem_model
  import srd_pkg::*;
(
  input  wire logic        clock,       // Core clock
  input  wire logic [11:0] mem_addr,    // Resolved address
  input  wire logic        gpr_sel,     // RAM select
  input  wire logic        gpr_wr,      // RAM write
  input  wire logic        periph_sel,  // Peripheral select
  input  wire logic        periph_wr,   // Peripheral write
  input  wire logic [7:0]  wr_data,     // Write data
  output logic      [7:0]  gpr_rdata,   // RAM read data
  output logic      [7:0]  periph_rdata // Peripheral read data
);
  logic [7:0] ram_ff [512];
  logic [7:0] per_ff;
  logic [7:0] cyc_ff = 8'h00;
  // Stores, and a wandering pattern for deselected lines
  always_ff @(posedge clock) begin
    cyc_ff <= cyc_ff + 8'h01;
    if (gpr_wr) ram_ff[mem_addr[8:0]] <= wr_data;
    if (periph_wr && mem_addr == 12'hF9F) per_ff <= wr_data;
  end
  // One peripheral register; any other selected address shows a fixed pattern,
  // so a hole or alias wrongly routed here reads back non-zero
  always_comb begin
    gpr_rdata = gpr_sel ? ram_ff[mem_addr[8:0]] : cyc_ff;
    periph_rdata = !periph_sel ? ~cyc_ff : (mem_addr == 12'hF9F) ? per_ff : 8'hE7;
  end
endmodule : srd_mem_model

// [tb/test_special_register_region_decode.sv]
// Testbench: register accesses through the region decoder
`timescale 1ns/100ps
module test_special_register_region_decode;
  import srd_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0, use_full = 1'b0, acc_bit = 1'b0;
  logic [11:0] addr = 12'h000, mem_addr;
  logic [7:0]  wr_data = 8'h00, periph_rdata, gpr_rdata, rd_data, stk_ptr;
  logic        gpr_sel, gpr_wr, periph_sel, periph_wr, alias_hit;
  logic [1:0]  alias_group;
  logic [3:0]  bank_sel;
  logic [20:0] tos_value;
  logic [21:0] tbl_ptr;
  int          n_mismatch = 0, checks_done = 0, cycles = 0;
  logic [7:0]  msk [11] = '{MASK_FULL, MASK_FULL, MASK_UP6, MASK_FULL, MASK_FULL, MASK_UP5,
                            MASK_RETURN_STACK_POINTER, MASK_FULL, MASK_FULL, MASK_UP5, MASK_BANK};
  srd_top i_srd_top (.clock, .rst_n, .rd_en, .wr_en, .use_full, .acc_bit, .addr, .wr_data, .periph_rdata,
    .gpr_rdata, .rd_data, .mem_addr, .gpr_sel, .gpr_wr, .periph_sel, .periph_wr, .alias_hit, .alias_group,
    .bank_sel, .tos_value, .tbl_ptr, .stk_ptr);
  srd_mem_model i_srd_mem_model (.clock, .mem_addr, .gpr_sel, .gpr_wr, .periph_sel, .periph_wr, .wr_data,
    .gpr_rdata, .periph_rdata);
  // 40 MHz clock and a cycle ceiling against hangs
  initial begin
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One access taken at the next edge; strobes stay up for back-to-back use
  task automatic acc(input logic wr, full, ab, input logic [11:0] a, input logic [7:0] d);
    wr_en = wr;
    rd_en = !wr;
    use_full = full;
    acc_bit = ab;
    addr = a;
    wr_data = d;
    @(posedge clock);
    #1;
  endtask : acc
  task automatic idle(input string name);
    wr_en = 1'b0;
    rd_en = 1'b0;
    @(posedge clock);
    #1;
    $display("test %s done", name);
  endtask : idle
  function automatic logic [11:0] ra(input int i);
    return (i < 10) ? OFS_TBLPTR_LO + 12'(i) : OFS_BANK_SEL;
  endfunction : ra
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 11; i++) begin
      acc(1'b0, 1'b1, 1'b0, ra(i), 8'h00);
      check("reset value", rd_data, 8'h00);
    end
    idle("reset");
    for (int i = 0; i < 11; i++) begin
      acc(1'b1, 1'b1, 1'b0, ra(i), 8'hFF);
      acc(1'b0, 1'b1, 1'b0, ra(i), 8'h00);
      check("masked readback", rd_data, msk[i]);
    end
    check("stack top", tos_value, 21'h1F_FFFF);
    check("table pointer", tbl_ptr, 22'h3F_FFFF);
    check("stack pointer", stk_ptr, MASK_RETURN_STACK_POINTER);
    idle("masks");
    for (int g = 0; g < 3; g++) begin
      acc(1'b1, 1'b1, 1'b0, ALIAS0_BASE - 12'(8 * g), 8'h5A);
      check("alias group", alias_group, 32'(g));
      acc(1'b0, 1'b1, 1'b0, ALIAS0_BASE - 12'(8 * g) - ALIAS_SPAN, 8'h00);
      check("alias hit", alias_hit, 1'b1);
      acc(1'b0, 1'b1, 1'b0, ALIAS0_BASE - 12'(8 * g), 8'h00);
      check("alias read", rd_data, 8'h00);
    end
    idle("aliases");
    acc(1'b1, 1'b1, 1'b0, 12'hF9C, 8'hA5);
    check("hole select", periph_sel, 1'b0);
    acc(1'b0, 1'b1, 1'b0, 12'hF9C, 8'h00);
    check("hole read", rd_data, 8'h00);
    acc(1'b1, 1'b1, 1'b0, 12'hF9F, 8'hC3);
    check("peripheral select", periph_sel, 1'b1);
    acc(1'b0, 1'b1, 1'b0, 12'hF9F, 8'h00);
    check("peripheral read", rd_data, 8'hC3);
    acc(1'b1, 1'b1, 1'b0, 12'hF7F, 8'h66);
    acc(1'b0, 1'b1, 1'b0, 12'hF7F, 8'h00);
    check("below region", rd_data, 8'h00);
    idle("holes");
    acc(1'b1, 1'b0, 1'b0, 12'h010, 8'h3C);
    check("access low", mem_addr, 12'h010);
    acc(1'b0, 1'b0, 1'b0, 12'h0FD, 8'h00);
    check("access high", mem_addr, 12'hFFD);
    acc(1'b1, 1'b1, 1'b0, OFS_BANK_SEL, 8'hF2);
    check("access read", rd_data, 8'hFF);
    acc(1'b1, 1'b0, 1'b1, 12'h010, 8'h77);
    check("bank upper bits", bank_sel, 4'h2);
    acc(1'b0, 1'b0, 1'b1, 12'h010, 8'h00);
    check("unpopulated bank read", rd_data, 8'h00);
    acc(1'b0, 1'b1, 1'b0, 12'h010, 8'h00);
    check("dropped write", rd_data, 8'h3C);
    acc(1'b1, 1'b1, 1'b0, OFS_BANK_SEL, 8'h01);
    acc(1'b1, 1'b0, 1'b1, 12'h020, 8'h99);
    acc(1'b0, 1'b1, 1'b0, 12'h120, 8'h00);
    acc(1'b0, 1'b1, 1'b0, 12'h120, 8'h00);
    check("bank one", rd_data, 8'h99);
    idle("banks");
    rst_n = 1'b0;
    @(posedge clock);
    #1 rst_n = 1'b1;
    acc(1'b0, 1'b1, 1'b0, OFS_TOS_UP, 8'h00);
    check("second reset", rd_data, 8'h00);
    check("bank after reset", bank_sel, 4'h0);
    idle("second reset");
    test_done();
  end
endmodule : test_special_register_region_decode
